// >>> rtl/mec_pkg.sv
// Constants, register map and carrier types of the memory error capture block.
// Assumes a 32-bit APB slave and a 39-bit memory word (check bits on top).
package mec_pkg;
	localparam int        MEC_DATA_W   = 32;
	localparam int        MEC_CHK_W    = 7;
	localparam int        MEC_WORD_W   = MEC_DATA_W + MEC_CHK_W;
	localparam int        MEC_PAGE_W   = 20;
	localparam int        MEC_ADDR_W   = 12;
	// Register byte offsets
	localparam logic [11:0] MEC_OFS_STATUS  = 12'h000;
	localparam logic [11:0] MEC_OFS_IRQSTAT = 12'h004;
	localparam logic [11:0] MEC_OFS_IRQCLR  = 12'h008;
	localparam logic [11:0] MEC_OFS_IRQEN   = 12'h00C;
	// Status register field positions and the systemControl keep bit
	localparam int        MEC_B_UNCORR = 31;
	localparam int        MEC_B_HIRATE = 30;
	localparam int        MEC_B_CORR   = 29;
	localparam int        MEC_B_PAGE   = 9;
	localparam int        MEC_B_DMA    = 8;
	localparam int        MEC_B_PARITY = 7;
	localparam int        MEC_SYS_KEEP = 7;
	// Interrupt event bits
	localparam int        MEC_IRQ_W    = 4;
	localparam int        MEC_I_CORR   = 0;
	localparam int        MEC_I_UNCORR = 1;
	localparam int        MEC_I_PARITY = 2;
	localparam int        MEC_I_DMA    = 3;
	localparam logic [6:0] MEC_SYN_NONE   = 7'h00;
	localparam logic [6:0] MEC_SYN_BADCHK = 7'h07;
	// Syndrome of a single flipped data bit, index = data bit
	localparam logic [6:0] MEC_DATA_SYN [0:31] = '{
		7'h58, 7'h1C, 7'h1A, 7'h5E, 7'h1F, 7'h5B, 7'h5D, 7'h19,
		7'h68, 7'h2C, 7'h2A, 7'h6E, 7'h2F, 7'h6B, 7'h6D, 7'h29,
		7'h70, 7'h34, 7'h32, 7'h76, 7'h37, 7'h73, 7'h75, 7'h31,
		7'h38, 7'h7C, 7'h7A, 7'h3E, 7'h7F, 7'h3B, 7'h3D, 7'h79};
	typedef enum logic [1:0] {MEC_RK_NONE, MEC_RK_CORR, MEC_RK_UNCORR,
		MEC_RK_PARITY} mec_rank_e;
	typedef struct packed {
		logic                  valid;
		logic                  isDma;
		logic                  parityErr;
		logic [MEC_PAGE_W-1:0] page;
		logic [MEC_DATA_W-1:0] data;
	} mec_wr_s;
	typedef struct packed {
		logic                  valid;
		logic                  isDma;
		logic [MEC_PAGE_W-1:0] page;
		logic [MEC_WORD_W-1:0] word;
	} mec_rd_s;
	typedef struct packed {
		logic                  valid;
		logic                  uncorr;
		logic [MEC_DATA_W-1:0] data;
	} mec_rdres_s;
endpackage

// >>> rtl/mec_memory_error_capture.sv
// Error capture, ECC generation/check and status register of main memory.
// Assumes write/read requests from controller logic on core_clk, an APB
// master on core_clk, and an asynchronous dc_power_ok pin.
`timescale 1ns/100ps
module mec_memory_error_capture (
	input  wire logic                       core_clk,    // 125 MHz clock
	input  wire logic                       srst,        // Sync reset, high
	input  wire logic                       dcPowerOk,   // Async pin
	input  wire logic [7:0]                 systemControl, // System control
	input  wire mec_pkg::mec_wr_s           wrReq,       // Write request
	input  wire mec_pkg::mec_rd_s           rdReq,       // Raw word read back
	output logic      [mec_pkg::MEC_WORD_W-1:0] memWord, // Word to store
	output logic                            memWordValid, // Store strobe
	output mec_pkg::mec_rdres_s             rdRes,       // Corrected read
	input  wire logic                       psel,        // APB select
	input  wire logic                       penable,     // APB enable
	input  wire logic                       pwrite,      // APB direction
	input  wire logic [mec_pkg::MEC_ADDR_W-1:0] paddr,   // APB byte address
	input  wire logic [31:0]                pwdata,      // APB write data
	output logic      [31:0]                prdata,      // APB read data
	output logic                            pready,      // APB ready
	output logic                            pslverr,     // Unmapped access
	output logic                            irq          // Level interrupt
);
	import mec_pkg::*;

	typedef struct packed {
		logic                  pwrOkMeta;
		logic                  pwrOkSync;
		logic                  pwrOkPrev;
		logic                  fUncorr;
		logic                  fHiRate;
		logic                  fCorr;
		logic                  fDma;
		logic                  fParity;
		mec_rank_e             rank;
		logic [MEC_PAGE_W-1:0] page;
		logic [6:0]            syn;
		logic [MEC_IRQ_W-1:0]  irqStat;
		logic [MEC_IRQ_W-1:0]  irqEn;
		logic                  irq;
		logic [MEC_WORD_W-1:0] memWord;
		logic                  memWordValid;
		mec_rdres_s            rdRes;
		logic [31:0]           prdata;
		logic                  pready;
		logic                  pslverr;
	} mec_state_s;

	mec_state_s st;
	mec_state_s next_st;

	// Check bits of a data word; syndrome = stored ^ recomputed
	function automatic logic [6:0] eccChk(input logic [MEC_DATA_W-1:0] d);
		logic [6:0] c;
		c = MEC_SYN_NONE;
		for (int i = 0; i < MEC_DATA_W; i++) begin
			if (d[i])
				c = c ^ MEC_DATA_SYN[i];
		end
		return c;
	endfunction

	// Returns {hit, position}; positions 32..38 are check bits
	function automatic logic [6:0] synPos(input logic [6:0] s);
		logic [6:0] r;
		r = 7'h00;
		for (int i = 0; i < MEC_DATA_W; i++) begin
			if (s == MEC_DATA_SYN[i])
				r = {1'b1, i[5:0]};
		end
		for (int j = 0; j < MEC_CHK_W; j++) begin
			if (s == (7'h01 << j))
				r = {1'b1, 6'(MEC_DATA_W + j)};
		end
		return r;
	endfunction

	logic [6:0]            rdSyn;
	logic [6:0]            rdPos;
	logic                  rdErr;
	logic                  rdSingle;
	logic                  wrParity;
	mec_rank_e             candRank;
	logic [MEC_PAGE_W-1:0] candPage;
	logic [6:0]            candSyn;
	logic                  envClear;
	logic                  apbAcc;
	logic                  apbWr;
	logic [31:0]           statusWord;

	always_comb begin
		rdSyn    = rdReq.word[MEC_WORD_W-1:MEC_DATA_W]
			^ eccChk(rdReq.word[MEC_DATA_W-1:0]);
		rdPos    = synPos(rdSyn);
		rdErr    = rdReq.valid && (rdSyn != MEC_SYN_NONE);
		rdSingle = rdErr && rdPos[6];
		// DMA writes skip the bus parity check
		wrParity = wrReq.valid && !wrReq.isDma && wrReq.parityErr;
		// Pick the higher-ranked of this cycle's events
		candRank = MEC_RK_NONE;
		candPage = rdReq.page;
		candSyn  = rdSyn;
		if (wrParity) begin
			candRank = MEC_RK_PARITY;
			candPage = wrReq.page;
			candSyn  = MEC_SYN_BADCHK;
		end else if (rdSingle) begin
			candRank = MEC_RK_CORR;
		end else if (rdErr) begin
			candRank = MEC_RK_UNCORR;
		end
		envClear = st.pwrOkPrev && !st.pwrOkSync
			&& !systemControl[MEC_SYS_KEEP];
		apbAcc   = psel && penable && st.pready;
		apbWr    = apbAcc && pwrite;
		statusWord = {st.fUncorr, st.fHiRate, st.fCorr, st.page,
			st.fDma, st.fParity, st.syn};
	end

	always_comb begin
		logic       wantClr;
		wantClr  = 1'b0;
		next_st = st;
		next_st.pwrOkMeta = dcPowerOk;
		next_st.pwrOkSync = st.pwrOkMeta;
		next_st.pwrOkPrev = st.pwrOkSync;

		// Write path: seven check bits on four data bytes
		next_st.memWordValid = wrReq.valid;
		if (wrReq.valid)
			next_st.memWord = {eccChk(wrReq.data)
				^ (wrParity ? MEC_SYN_BADCHK : MEC_SYN_NONE),
				wrReq.data};

		// Read path: correct data bits, check-bit hits need no fix
		next_st.rdRes.valid  = rdReq.valid;
		next_st.rdRes.uncorr = rdErr && !rdSingle;
		if (rdReq.valid) begin
			next_st.rdRes.data = rdReq.word[MEC_DATA_W-1:0];
			if (rdSingle && rdPos[5:0] < 6'(MEC_DATA_W))
				next_st.rdRes.data[rdPos[4:0]] =
					!rdReq.word[rdPos[4:0]];
		end

		// Software clears first, so a same-cycle event wins
		if (apbWr && paddr == MEC_OFS_STATUS) begin
			if (pwdata[MEC_B_UNCORR]) next_st.fUncorr = 1'b0;
			if (pwdata[MEC_B_HIRATE]) next_st.fHiRate = 1'b0;
			if (pwdata[MEC_B_CORR])   next_st.fCorr   = 1'b0;
			if (pwdata[MEC_B_DMA])    next_st.fDma    = 1'b0;
			if (pwdata[MEC_B_PARITY]) next_st.fParity = 1'b0;
			wantClr = 1'b1;
		end
		// Page field takes no software data at all
		if (apbWr && paddr == MEC_OFS_IRQCLR)
			next_st.irqStat = st.irqStat & ~pwdata[MEC_IRQ_W-1:0];
		if (apbWr && paddr == MEC_OFS_IRQEN)
			next_st.irqEn = pwdata[MEC_IRQ_W-1:0];
		// Rank falls back once every ranked flag has been cleared
		if (wantClr && !next_st.fUncorr && !next_st.fCorr
				&& !next_st.fParity)
			next_st.rank = MEC_RK_NONE;

		if (wrParity) begin
			next_st.fParity = 1'b1;
			next_st.irqStat[MEC_I_PARITY] = 1'b1;
		end
		if (rdErr && !rdSingle) begin
			next_st.fHiRate = next_st.fHiRate | st.fUncorr;
			next_st.fUncorr = 1'b1;
			next_st.irqStat[MEC_I_UNCORR] = 1'b1;
		end
		if (rdSingle) begin
			next_st.fCorr = 1'b1;
			next_st.irqStat[MEC_I_CORR] = 1'b1;
		end
		if (rdErr && rdReq.isDma) begin
			next_st.fDma = 1'b1;
			next_st.irqStat[MEC_I_DMA] = 1'b1;
		end
		// Strictly higher rank only; page and syndrome move together
		if (candRank > next_st.rank) begin
			next_st.rank = candRank;
			next_st.page = candPage;
			next_st.syn  = candSyn;
		end

		// Power-ok loss with systemControl bit 7 clear acts like reset on the status register
		if (envClear) begin
			next_st.fUncorr = 1'b0;
			next_st.fHiRate = 1'b0;
			next_st.fCorr   = 1'b0;
			next_st.fDma    = 1'b0;
			next_st.fParity = 1'b0;
			next_st.rank    = MEC_RK_NONE;
			next_st.page    = '0;
			next_st.syn     = MEC_SYN_NONE;
		end
		next_st.irq = |(next_st.irqStat & next_st.irqEn);

		// APB: one wait state, ready for a single cycle
		next_st.pready  = psel && penable && !st.pready;
		next_st.pslverr = 1'b0;
		next_st.prdata  = '0;
		if (psel && penable && !st.pready) begin
			case (paddr)
				MEC_OFS_STATUS:  next_st.prdata = statusWord;
				MEC_OFS_IRQSTAT: next_st.prdata = 32'(st.irqStat);
				MEC_OFS_IRQCLR:  next_st.prdata = '0;
				MEC_OFS_IRQEN:   next_st.prdata = 32'(st.irqEn);
				default:         next_st.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst)
			st <= '0;
		else
			st <= next_st;
	end

	assign memWord      = st.memWord;
	assign memWordValid = st.memWordValid;
	assign rdRes        = st.rdRes;
	assign prdata       = st.prdata;
	assign pready       = st.pready;
	assign pslverr      = st.pslverr;
	assign irq          = st.irq;

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);

	property p_pageRo;
		apbWr && paddr == MEC_OFS_STATUS && candRank == MEC_RK_NONE
			&& !envClear |=> $stable(st.page) && $stable(st.syn);
	endproperty
	a_pageRo: assert property (p_pageRo)
		else $error("page field changed by a software write");

	property p_equalRank;
		st.rank != MEC_RK_NONE && candRank == st.rank && !apbWr
			&& !envClear |=> $stable(st.page);
	endproperty
	a_equalRank: assert property (p_equalRank)
		else $error("equal-ranked error overwrote the page");

	property p_parityTop;
		// A parity error already held keeps its own page
		wrParity && st.rank != MEC_RK_PARITY && !envClear
			|=> st.rank == MEC_RK_PARITY
			&& st.page == $past(wrReq.page) && st.fParity;
	endproperty
	a_parityTop: assert property (p_parityTop)
		else $error("parity error not captured at top rank");

	property p_badCheck;
		wrParity |=> memWordValid && (memWord[MEC_WORD_W-1:MEC_DATA_W]
			^ eccChk(memWord[MEC_DATA_W-1:0])) == MEC_SYN_BADCHK;
	endproperty
	a_badCheck: assert property (p_badCheck)
		else $error("bad check bits not written on parity error");

	property p_dmaFlag;
		rdErr && rdReq.isDma && !envClear
			|=> st.fDma && st.irqStat[MEC_I_DMA];
	endproperty
	a_dmaFlag: assert property (p_dmaFlag)
		else $error("DMA error flag not set");

	property p_uncorr;
		rdErr && !rdSingle && !envClear |=> st.fUncorr && rdRes.uncorr;
	endproperty
	a_uncorr: assert property (p_uncorr)
		else $error("multi-bit error not flagged");

	property p_corr;
		rdSingle && !envClear |=> st.fCorr && !rdRes.uncorr;
	endproperty
	a_corr: assert property (p_corr)
		else $error("single-bit error not flagged");

	property p_envClear;
		envClear |=> st.page == '0 && st.syn == MEC_SYN_NONE
			&& !st.fParity && !st.fDma && !st.fUncorr;
	endproperty
	a_envClear: assert property (p_envClear)
		else $error("status not cleared on power-ok loss");

	property p_w1c;
		apbWr && paddr == MEC_OFS_STATUS && pwdata[MEC_B_PARITY]
			&& !wrParity |=> !st.fParity;
	endproperty
	a_w1c: assert property (p_w1c)
		else $error("parity flag not cleared by written one");
endmodule

// >>> tb/mec_bus_partner.sv
// Behavioural CPU and DMA requester with a small backing store.
// Assumes tasks are entered just after a rising edge of core_clk.
`timescale 1ns/100ps
module mec_bus_partner (
	input  wire logic                          core_clk,     // Block clock
	input  wire logic [mec_pkg::MEC_WORD_W-1:0] memWord,     // Word to store
	input  wire logic                          memWordValid, // Store strobe
	input  wire mec_pkg::mec_rdres_s           rdRes,        // Read result
	output mec_pkg::mec_wr_s                   wrReq,        // Write request
	output mec_pkg::mec_rd_s                   rdReq         // Read request
);
	import mec_pkg::*;
	logic [MEC_WORD_W-1:0] mem [0:15];
	logic [3:0]            wrSlot = 4'h0;
	mec_rdres_s            lastRes = '0;
	initial wrReq = '0;
	initial rdReq = '0;
	// Whole words with check bits on top are kept
	always @(posedge core_clk) begin
		if (memWordValid)
			mem[wrSlot] <= memWord;
		if (rdRes.valid)
			lastRes <= rdRes;
	end
	// Released fields are inverted so stale values are never trusted
	task automatic write(input logic [19:0] pg, input logic [31:0] d,
		input logic dma, input logic par);
		wrSlot <= pg[3:0];
		wrReq <= '{1'b1, dma, par, pg, d};
		@(posedge core_clk);
		wrReq <= {1'b0, ~wrReq[$bits(mec_wr_s)-2:0]};
		repeat (2) @(posedge core_clk);
	endtask
	// Flip mask models corrupted cells on the way back
	task automatic read(input logic [19:0] pg, input logic dma,
		input logic [MEC_WORD_W-1:0] flip);
		rdReq <= '{1'b1, dma, pg, mem[pg[3:0]] ^ flip};
		@(posedge core_clk);
		rdReq <= {1'b0, ~rdReq[$bits(mec_rd_s)-2:0]};
		repeat (2) @(posedge core_clk);
	endtask
endmodule

// >>> tb/mec_memory_error_capture_tb.sv
// Self-checking bench of the memory error capture block.
// Assumes the partner model drives requests and APB runs on core_clk.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin nTests++; if ((g) !== (e)) begin \
	badCount++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
	end end
module mec_memory_error_capture_tb;
	import mec_pkg::*;
	logic                  core_clk = 1'b0;
	logic                  srst = 1'b1;
	logic                  dcPowerOk = 1'b1;
	logic [7:0]            systemControl = 8'h00;
	mec_wr_s               wrReq;
	mec_rd_s               rdReq;
	logic [MEC_WORD_W-1:0] memWord;
	logic                  memWordValid;
	mec_rdres_s            rdRes;
	logic                  psel = 1'b0;
	logic                  penable = 1'b0;
	logic                  pwrite = 1'b0;
	logic [11:0]           paddr = 12'h000;
	logic [31:0]           pwdata = 32'h0000_0000;
	logic [31:0]           prdata;
	logic [31:0]           rdat;
	logic                  pready;
	logic                  pslverr;
	logic                  slv;
	logic                  irq;
	int                    badCount = 0;
	int                    nTests = 0;
	always #4 core_clk = ~core_clk;
	mec_memory_error_capture mec_memory_error_capture_i (.core_clk(core_clk),
		.srst(srst), .dcPowerOk(dcPowerOk), .systemControl(systemControl),
		.wrReq(wrReq), .rdReq(rdReq), .memWord(memWord),
		.memWordValid(memWordValid), .rdRes(rdRes), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	mec_bus_partner mec_bus_partner_i (.core_clk(core_clk), .memWord(memWord),
		.memWordValid(memWordValid), .rdRes(rdRes), .wrReq(wrReq),
		.rdReq(rdReq));
	task automatic stopTest();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Values read right after the edge are those sampled at it
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			badCount++;
			stopTest();
		end
		rdat = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rdChk(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, e, rdat)
	endtask
	function automatic logic [31:0] st(input logic u, input logic c,
		input logic d, input logic p, input logic [19:0] pg,
		input logic [6:0] s);
		return {u, 1'b0, c, pg, d, p, s};
	endfunction
	initial begin
		repeat (20000) @(posedge core_clk);
		badCount++;
		$display("CHECK FAILED watchdog exp done got hang");
		stopTest();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		srst <= 1'b0;
		@(posedge core_clk);
		rdChk(MEC_OFS_STATUS, 32'h0000_0000, "reset status");
		mec_bus_partner_i.write(20'h00001, 32'h0000_0001, 1'b0, 1'b0);
		`CHK("word", 39'h58_0000_0001, mec_bus_partner_i.mem[1])
		mec_bus_partner_i.read(20'h00001, 1'b0, 39'h00_0000_0001);
		`CHK("fix", 32'h0000_0001, mec_bus_partner_i.lastRes.data)
		rdChk(MEC_OFS_STATUS, st(0, 1, 0, 0, 1, 7'h58), "corr");
		mec_bus_partner_i.write(20'h00002, 32'h0000_0000, 1'b0, 1'b0);
		mec_bus_partner_i.read(20'h00002, 1'b0, 39'h00_8000_0000);
		rdChk(MEC_OFS_STATUS, st(0, 1, 0, 0, 1, 7'h58), "same");
		mec_bus_partner_i.write(20'h00003, 32'h0000_0000, 1'b0, 1'b0);
		mec_bus_partner_i.read(20'h00003, 1'b0, 39'h00_8000_0001);
		`CHK("multi", 1'b1, mec_bus_partner_i.lastRes.uncorr)
		rdChk(MEC_OFS_STATUS, st(1, 1, 0, 0, 3, 7'h21), "unc");
		$display("test ecc capture done");
		mec_bus_partner_i.write(20'h00004, 32'h0000_0000, 1'b0, 1'b1);
		rdChk(MEC_OFS_STATUS, st(1, 1, 0, 1, 4, 7'h07), "par");
		apb(1'b1, MEC_OFS_STATUS, 32'h1FFF_FE7F);
		rdChk(MEC_OFS_STATUS, st(1, 1, 0, 1, 4, 7'h07), "ro");
		apb(1'b1, MEC_OFS_STATUS, 32'hA000_0180);
		rdChk(MEC_OFS_STATUS, st(0, 0, 0, 0, 4, 7'h07), "w1c");
		mec_bus_partner_i.read(20'h00004, 1'b0, 39'h00_0000_0000);
		rdChk(MEC_OFS_STATUS, st(1, 0, 0, 0, 4, 7'h07), "bad");
		mec_bus_partner_i.read(20'h00003, 1'b0, 39'h00_8000_0001);
		rdChk(MEC_OFS_STATUS, 32'hC000_0807, "rate");
		apb(1'b1, MEC_OFS_STATUS, 32'hE000_0180);
		mec_bus_partner_i.read(20'h00001, 1'b1, 39'h00_0000_0001);
		rdChk(MEC_OFS_STATUS, st(0, 1, 1, 0, 1, 7'h58), "dma");
		apb(1'b1, MEC_OFS_STATUS, 32'h0000_0100);
		rdChk(MEC_OFS_STATUS, st(0, 1, 0, 0, 1, 7'h58), "dma w1c");
		$display("test priority and clear done");
		rdChk(MEC_OFS_IRQSTAT, 32'h0000_000F, "irq status");
		`CHK("irq masked", 1'b0, irq)
		apb(1'b1, MEC_OFS_IRQEN, 32'h0000_0001);
		repeat (2) @(posedge core_clk);
		`CHK("irq on", 1'b1, irq)
		apb(1'b1, MEC_OFS_IRQCLR, 32'h0000_000F);
		rdChk(MEC_OFS_IRQCLR, 32'h0000_0000, "irq clear reads");
		repeat (2) @(posedge core_clk);
		`CHK("irq off", 1'b0, irq)
		rdChk(MEC_OFS_IRQSTAT, 32'h0000_0000, "irq cleared");
		apb(1'b0, 12'h010, 32'h0000_0000);
		`CHK("unmapped err", 1'b1, slv)
		`CHK("unmapped data", 32'h0000_0000, rdat)
		$display("test interrupt and bus done");
		systemControl <= 8'h80;
		dcPowerOk <= 1'b0;
		repeat (8) @(posedge core_clk);
		rdChk(MEC_OFS_STATUS, st(0, 1, 0, 0, 1, 7'h58), "keep");
		dcPowerOk <= 1'b1;
		systemControl <= 8'h00;
		repeat (8) @(posedge core_clk);
		dcPowerOk <= 1'b0;
		repeat (8) @(posedge core_clk);
		rdChk(MEC_OFS_STATUS, 32'h0000_0000, "power clear");
		dcPowerOk <= 1'b1;
		$display("test power clear done");
		stopTest();
	end
endmodule
